// *** rtl/mlis_pkg.sv ***
// constants and types shared by the monitor link i2c slave port
package mlis_pkg;

  localparam int BUS_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 3;

  // register word index on the avalon slave
  localparam logic [IDX_W-1:0] IDX_CONTROL = 3'h0;
  localparam logic [IDX_W-1:0] IDX_EVENT   = 3'h1;
  localparam logic [IDX_W-1:0] IDX_ERROR   = 3'h2;
  localparam logic [IDX_W-1:0] IDX_DATA    = 3'h3;
  localparam logic [IDX_W-1:0] IDX_OWN     = 3'h4;

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // slave_control fields
  localparam int CTL_UNIT_ON = 5;
  localparam int CTL_ALT_EN  = 4;
  localparam int CTL_REPLY   = 2;
  localparam int CTL_RELEASE = 1;
  localparam int CTL_IRQ_EN  = 0;

  // event_status fields
  localparam int EVS_EVENT     = 7;
  localparam int EVS_TX_DIR    = 5;
  localparam int EVS_BUSY      = 4;
  localparam int EVS_BYTE_DONE = 3;
  localparam int EVS_ADDR_HIT  = 2;

  // error_status fields
  localparam int ERS_ACK_FAIL  = 4;
  localparam int ERS_STOP_SEEN = 3;
  localparam int ERS_MISPLACED = 1;
  localparam int ERS_ALT_SEEN  = 0;

  // fixed alternate address pair, compared on bits 7:1
  localparam logic [REG_W-1:0] ALT_ADDRESS = 8'h60;
  localparam logic [REG_W-1:0] START_BYTE  = 8'h01;

  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [3:0] COUNT_ZERO  = 4'h0;
  localparam logic [3:0] COUNT_STEP  = 4'h1;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX_LOAD,
    ST_TX,
    ST_TX_ACK,
    ST_IGNORE
  } mlis_state_e;

  // a start or stop now would cut a byte in half; the first clock high
  // of a received byte is where a proper stop or restart lands, so it is legal; a sent byte is mid-byte throughout
  function automatic logic mlis_mid_byte(input mlis_state_e st,
                                         input logic [3:0]  cnt);
    mlis_mid_byte = ((st == ST_ADDR || st == ST_RX) && cnt > COUNT_STEP)
                    || st == ST_TX;
  endfunction : mlis_mid_byte

endpackage : mlis_pkg

// *** rtl/mlis_sync.sv ***
// three-stage synchroniser with agreement filter for bus pins
`timescale 1ns/1ns
module mlis_sync #(
  parameter int         W           = 2,
  parameter logic [1:0] RESET_LEVEL = 2'b11
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] raw_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= RESET_LEVEL[W-1:0];
      stage2 <= RESET_LEVEL[W-1:0];
      stage3 <= RESET_LEVEL[W-1:0];
    end else begin
      stage1 <= raw_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      level_o <= RESET_LEVEL[W-1:0];
    end else begin
      level_o <= (~(stage2 ^ stage3) & stage3)
                 | ((stage2 ^ stage3) & level_o);
    end
  end

endmodule : mlis_sync

// *** rtl/mlis_cond.sv ***
// clock edge and start/stop detector on filtered bus levels
`timescale 1ns/1ns
module mlis_cond (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_rise_o,
  output logic      scl_fall_o,
  output logic      start_o,
  output logic      stop_o
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise_o = scl_i & ~scl_q;
  assign scl_fall_o = ~scl_i & scl_q;
  // data moving while the clock stays high marks a condition
  assign start_o    = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_o     = scl_i & scl_q & ~sda_q & sda_i;

endmodule : mlis_cond

// *** rtl/mlis_slave.sv ***
// monitor link i2c slave port with avalon register access
// Function
// - alternate pair 60h/61h answered when enabled
// - reply enable drives acknowledge, cleared off
// - release request frees lines after byte
// - irq enable gates requests, cleared off
// - clock held low while byte/address flags
// - event flag ORs byte done, hit and errors but alt seen
// - direction flag shows transmit or receive
// - busy follows start/stop even when off
// - byte done cleared by status-data sequence
// - byte done set after acknowledge pulse
// - address hit on own or alternate match
// - acknowledge failure flag, no clock hold
// - stop after acknowledge slot sets flag
// - misplaced start/stop sets error flag
// - alternate seen cleared by start/stop
// - data write launches transmit shifting
// - receive capture paced by data reads
// - compare bits 7:1, keep own address
// - address byte 01h never answered
// - unused register bits read zero
// - unit on, double write to configure
// - address lsb picks receive or transmit
// - misplaced condition discards byte
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module mlis_slave
  import mlis_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic [IDX_W-1:0] avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [BUS_W-1:0] avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [BUS_W-1:0] avs_readdata_o,
  output logic                  avs_waitrequest_o,
  input  wire logic             monitor_clock_line_i,
  output logic                  monitor_clock_line_o,
  output logic                  monitor_clock_line_oe_o,
  input  wire logic             monitor_data_line_i,
  output logic                  monitor_data_line_o,
  output logic                  monitor_data_line_oe_o,
  output logic                  irq_o
);
  logic [1:0]       pins_f;
  logic             scl_f;
  logic             sda_f;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_c;
  logic             stop_c;
  mlis_state_e      state;
  logic [3:0]       bit_count;
  logic [REG_W-1:0] shift;
  logic             sda_drive;
  logic             ack_sample;
  logic             after_ack;
  logic             unit_on;
  logic             alt_address_enable;
  logic             reply_enable;
  logic             release_request;
  logic             irq_enable;
  logic             byte_done;
  logic             address_hit;
  logic             tx_direction;
  logic             ack_failure;
  logic             stop_seen;
  logic             misplaced_condition_error;
  logic             alt_address_seen;
  logic             bus_busy;
  logic             status_armed;
  logic [REG_W-1:0] own_slave_address;
  logic [REG_W-1:0] transfer_data;
  logic             event_flag;
  logic             access;
  logic             lane0;
  logic             rd_event;
  logic             rd_error;
  logic             rd_data;
  logic             wr_data;
  logic             wr_ctl;
  logic             wr_own;
  logic             mid;
  logic             release_now;
  logic             addr_own;
  logic             addr_alt;
  logic             addr_ok;
  logic             byte_end;
  logic             set_addr_hit;
  logic             cap_rx;
  logic             set_rx_done;
  logic             set_tx_done;
  logic             set_ack_fail;
  logic             set_stop;
  logic             set_misplaced;
  logic             set_alt;
  logic             clr_rx;
  logic             load_tx;
  logic             hold_clock;
  logic [REG_W-1:0] next_rd_byte;

  mlis_sync #(
    .W           (2),
    .RESET_LEVEL (2'b11)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .raw_i     ({monitor_clock_line_i, monitor_data_line_i}),
    .level_o   (pins_f)
  );
  assign scl_f = pins_f[1];
  assign sda_f = pins_f[0];

  mlis_cond u_cond (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .scl_i      (scl_f),
    .sda_i      (sda_f),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_c),
    .stop_o     (stop_c)
  );

  // bus access is acted on in the cycle waitrequest is still high
  assign access   = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  assign lane0    = avs_byteenable_i[0];
  assign rd_event = access & avs_read_i & avs_address_i == IDX_EVENT;
  assign rd_error = access & avs_read_i & avs_address_i == IDX_ERROR;
  assign rd_data  = access & avs_read_i & avs_address_i == IDX_DATA;
  assign wr_data  = access & avs_write_i & lane0
                    & avs_address_i == IDX_DATA;
  assign wr_ctl   = access & avs_write_i & lane0
                    & avs_address_i == IDX_CONTROL;
  assign wr_own   = access & avs_write_i & lane0
                    & avs_address_i == IDX_OWN;

  assign mid         = mlis_mid_byte(state, bit_count);
  assign release_now = release_request & ~mid;
  assign byte_end    = scl_fall & bit_count == BYTE_BITS;
  assign addr_own    = shift[7:1] == own_slave_address[7:1];
  assign addr_alt    = alt_address_enable
                       & shift[7:1] == ALT_ADDRESS[7:1];
  assign addr_ok     = (addr_own | addr_alt) & shift != START_BYTE
                       & reply_enable;

  assign set_addr_hit  = scl_fall & state == ST_ADDR_ACK;
  assign cap_rx        = scl_fall & state == ST_RX_ACK;
  assign set_rx_done   = cap_rx & reply_enable;
  assign set_tx_done   = scl_fall & state == ST_TX_ACK & ~ack_sample;
  assign set_ack_fail  = scl_fall & state == ST_TX_ACK & ack_sample;
  assign set_stop      = unit_on & stop_c & after_ack & reply_enable;
  assign set_misplaced = unit_on & (start_c | stop_c) & mid;
  assign set_alt       = state == ST_ADDR & byte_end & addr_alt
                         & shift != START_BYTE;
  assign clr_rx  = rd_data & status_armed & byte_done & ~tx_direction;
  assign load_tx = wr_data & state == ST_TX_LOAD & status_armed
                   & ~address_hit;

  assign event_flag = byte_done | address_hit | ack_failure
                      | stop_seen | misplaced_condition_error;
  assign hold_clock = byte_done | address_hit | state == ST_TX_LOAD;

  // first write only turns the unit on; clearing it wipes the control
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      unit_on            <= 1'b0;
      alt_address_enable <= 1'b0;
      reply_enable       <= 1'b0;
      release_request    <= 1'b0;
      irq_enable         <= 1'b0;
    end else if (wr_ctl) begin
      unit_on            <= avs_writedata_i[CTL_UNIT_ON];
      if (avs_writedata_i[CTL_UNIT_ON] && unit_on) begin
        alt_address_enable <= avs_writedata_i[CTL_ALT_EN];
        reply_enable       <= avs_writedata_i[CTL_REPLY];
        release_request    <= avs_writedata_i[CTL_RELEASE];
        irq_enable         <= avs_writedata_i[CTL_IRQ_EN];
      end else begin
        alt_address_enable <= 1'b0;
        reply_enable       <= 1'b0;
        release_request    <= 1'b0;
        irq_enable         <= 1'b0;
      end
    end
  end

  // own address survives the unit being switched off
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      own_slave_address <= REG_RESET;
    end else if (wr_own) begin
      own_slave_address <= avs_writedata_i[REG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_busy <= 1'b0;
    end else if (start_c) begin
      bus_busy <= 1'b1;
    end else if (stop_c) begin
      bus_busy <= 1'b0;
    end
  end

  // a status read opens the read-data or write-data clearing step
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_armed <= 1'b0;
    end else if (!unit_on || clr_rx || load_tx) begin
      status_armed <= 1'b0;
    end else if (rd_event) begin
      status_armed <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      transfer_data <= REG_RESET;
    end else if (set_addr_hit || cap_rx) begin
      transfer_data <= shift;
    end else if (wr_data) begin
      transfer_data <= avs_writedata_i[REG_W-1:0];
    end
  end

  // clears come first so that a same-cycle set wins
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byte_done                 <= 1'b0;
      address_hit               <= 1'b0;
      tx_direction              <= 1'b0;
      ack_failure               <= 1'b0;
      stop_seen                 <= 1'b0;
      misplaced_condition_error <= 1'b0;
      alt_address_seen          <= 1'b0;
    end else if (!unit_on) begin
      byte_done                 <= 1'b0;
      address_hit               <= 1'b0;
      tx_direction              <= 1'b0;
      ack_failure               <= 1'b0;
      stop_seen                 <= 1'b0;
      misplaced_condition_error <= 1'b0;
      alt_address_seen          <= 1'b0;
    end else begin
      if (rd_event) address_hit <= 1'b0;
      if (clr_rx || load_tx || stop_c) begin
        byte_done    <= clr_rx || load_tx ? 1'b0 : byte_done;
        tx_direction <= 1'b0;
      end
      if (rd_error) begin
        ack_failure               <= 1'b0;
        stop_seen                 <= 1'b0;
        misplaced_condition_error <= 1'b0;
      end
      if (start_c || stop_c) alt_address_seen <= 1'b0;
      if (set_addr_hit) address_hit <= 1'b1;
      if (set_rx_done) begin
        byte_done    <= 1'b1;
        tx_direction <= 1'b0;
      end
      if (set_tx_done) begin
        byte_done    <= 1'b1;
        tx_direction <= 1'b1;
      end
      if (set_ack_fail) ack_failure <= 1'b1;
      if (set_stop) stop_seen <= 1'b1;
      if (set_misplaced) misplaced_condition_error <= 1'b1;
      if (set_alt) alt_address_seen <= 1'b1;
    end
  end

  // serial engine: counts rises while receiving, falls while sending
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state      <= ST_IDLE;
      bit_count  <= COUNT_ZERO;
      shift      <= REG_RESET;
      sda_drive  <= 1'b0;
      ack_sample <= 1'b0;
      after_ack  <= 1'b0;
    end else if (!unit_on || stop_c) begin
      state     <= ST_IDLE;
      bit_count <= COUNT_ZERO;
      sda_drive <= 1'b0;
      after_ack <= 1'b0;
    end else if (start_c) begin
      state     <= ST_ADDR;
      bit_count <= COUNT_ZERO;
      sda_drive <= 1'b0;
      after_ack <= 1'b0;
    end else if (release_now && state != ST_IDLE) begin
      state     <= ST_IGNORE;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift     <= {shift[6:0], sda_f};
            bit_count <= bit_count + COUNT_STEP;
            if (bit_count != COUNT_ZERO) after_ack <= 1'b0;
          end else if (byte_end) begin
            bit_count <= COUNT_ZERO;
            if (state == ST_RX) begin
              sda_drive <= reply_enable;
              state     <= ST_RX_ACK;
            end else if (addr_ok) begin
              sda_drive <= 1'b1;
              state     <= ST_ADDR_ACK;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_drive <= 1'b0;
            after_ack <= 1'b1;
            state     <= shift[0] ? ST_TX_LOAD : ST_RX;
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            sda_drive <= 1'b0;
            after_ack <= 1'b1;
            state     <= ST_RX;
          end
        end
        ST_TX_LOAD: begin
          if (load_tx) begin
            shift     <= avs_writedata_i[REG_W-1:0];
            sda_drive <= ~avs_writedata_i[REG_W-1];
            bit_count <= COUNT_ZERO;
            state     <= ST_TX;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            after_ack <= 1'b0;
          end else if (scl_fall) begin
            if (bit_count == LAST_TX_BIT) begin
              bit_count <= COUNT_ZERO;
              sda_drive <= 1'b0;
              state     <= ST_TX_ACK;
            end else begin
              bit_count <= bit_count + COUNT_STEP;
              shift     <= {shift[6:0], 1'b0};
              sda_drive <= ~shift[6];
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_sample <= sda_f;
          end else if (scl_fall) begin
            after_ack <= 1'b1;
            state     <= ack_sample ? ST_IGNORE : ST_TX_LOAD;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          state <= state;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // open-drain lines: only ever pulled low, enable high while pulling
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      monitor_clock_line_o    <= 1'b0;
      monitor_clock_line_oe_o <= 1'b0;
      monitor_data_line_o     <= 1'b0;
      monitor_data_line_oe_o  <= 1'b0;
    end else begin
      monitor_clock_line_o    <= 1'b0;
      monitor_data_line_o     <= 1'b0;
      monitor_clock_line_oe_o <= unit_on & hold_clock & ~release_now;
      monitor_data_line_oe_o  <= unit_on & sda_drive & ~release_now;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_enable & (event_flag | alt_address_seen);
    end
  end

  always_comb begin
    next_rd_byte = REG_RESET;
    case (avs_address_i)
      IDX_CONTROL: begin
        next_rd_byte[CTL_UNIT_ON] = unit_on;
        next_rd_byte[CTL_ALT_EN]  = alt_address_enable;
        next_rd_byte[CTL_REPLY]   = reply_enable;
        next_rd_byte[CTL_RELEASE] = release_request;
        next_rd_byte[CTL_IRQ_EN]  = irq_enable;
      end
      IDX_EVENT: begin
        next_rd_byte[EVS_EVENT]     = event_flag;
        next_rd_byte[EVS_TX_DIR]    = tx_direction;
        next_rd_byte[EVS_BUSY]      = bus_busy;
        next_rd_byte[EVS_BYTE_DONE] = byte_done;
        next_rd_byte[EVS_ADDR_HIT]  = address_hit;
      end
      IDX_ERROR: begin
        next_rd_byte[ERS_ACK_FAIL]  = ack_failure;
        next_rd_byte[ERS_STOP_SEEN] = stop_seen;
        next_rd_byte[ERS_MISPLACED] = misplaced_condition_error;
        next_rd_byte[ERS_ALT_SEEN]  = alt_address_seen;
      end
      IDX_DATA: next_rd_byte = transfer_data;
      IDX_OWN:  next_rd_byte = own_slave_address;
      default:  next_rd_byte = REG_RESET;
    endcase
  end

  // every access answers one cycle after it is seen
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= {BUS_W{1'b0}};
    end else if (!avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b1;
    end else if (avs_read_i || avs_write_i) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= {{(BUS_W-REG_W){1'b0}}, next_rd_byte};
    end
  end

  a_clock_stretch: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    unit_on && (byte_done || address_hit) && !release_request
    |=> monitor_clock_line_oe_o)
    else $error("clock not held while an event waits");

  a_busy_track: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    start_c |=> bus_busy ##0 (stop_c ? 1'b1 : 1'b1))
    else $error("busy flag missed a start");

  a_hit_address: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(address_hit) |-> shift != START_BYTE
    && (addr_own || (alt_address_enable
        && shift[7:1] == ALT_ADDRESS[7:1])))
    else $error("address hit without a valid match");

  a_off_clears: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !unit_on |=> !irq_enable && !reply_enable && !release_request
    && !byte_done && !address_hit && !stop_seen && !irq_o)
    else $error("state left over while unit is off");

  a_dir_follows: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    tx_direction |-> byte_done)
    else $error("direction flag set without byte done");

  a_irq_gate: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !irq_enable [*2] |-> !irq_o)
    else $error("interrupt raised while disabled");

  a_reserved_zero: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !avs_waitrequest_o |-> avs_readdata_o[BUS_W-1:REG_W] == '0)
    else $error("upper read bits not zero");

  a_bus_answer: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle long");

  a_ack_no_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ack_failure && !byte_done && !address_hit && state != ST_TX_LOAD
    |=> !monitor_clock_line_oe_o)
    else $error("clock held for an error flag");

  a_rx_release: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    clr_rx && !set_rx_done |=> !byte_done)
    else $error("byte done not cleared by data read");

endmodule : mlis_slave

// *** tb/mlis_host_model.sv ***
// behavioural serial bus master standing in for the video host
`timescale 1ns/1ns
module mlis_host_model (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_drv_o,
  output logic      sda_drv_o
);
  // both lines are pulled up, so a released line reads high
  initial begin
    scl_drv_o = 1'b1;
    sda_drv_o = 1'b1;
  end
  task automatic start_cond;
    sda_drv_o = 1'b1;
    #62 scl_drv_o = 1'b1;
    wait (scl_i);
    #62 sda_drv_o = 1'b0;
    #62 scl_drv_o = 1'b0;
  endtask : start_cond
  // nine bits msb first, the last one is the acknowledge slot
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      sda_drv_o = o[k];
      #62 scl_drv_o = 1'b1;
      // the slave may stretch the low phase
      wait (scl_i);
      #31 i[k] = sda_i;
      #32 scl_drv_o = 1'b0;
    end
    sda_drv_o = 1'b1;
  endtask : xfer
  // one lone bit, used to cut a byte short
  task automatic pulse(input logic b);
    sda_drv_o = b;
    #62 scl_drv_o = 1'b1;
    wait (scl_i);
    #63 scl_drv_o = 1'b0;
  endtask : pulse
  task automatic stop_cond;
    sda_drv_o = 1'b0;
    #62 scl_drv_o = 1'b1;
    wait (scl_i);
    #62 sda_drv_o = 1'b1;
    #62;
  endtask : stop_cond
endmodule : mlis_host_model

// *** tb/mlis_slave_tb.sv ***
// self-checking bench for the monitor link i2c slave port
`timescale 1ns/1ns
module mlis_slave_tb
  import mlis_pkg::*;
;
  logic             ref_clk_i = 1'b0;
  logic             rst_i     = 1'b1;
  logic [IDX_W-1:0] adr       = '0;
  logic             rd        = 1'b0;
  logic             wr        = 1'b0;
  logic [BUS_W-1:0] wdat      = '0;
  logic [BUS_W-1:0] rdat;
  logic             wt, scl_oe, sda_oe, scl_o, sda_o, irq, scl_m, sda_m;
  wire              scl       = scl_m & (scl_oe ? scl_o : 1'b1);
  wire              sda       = sda_m & (sda_oe ? sda_o : 1'b1);
  int               n_mismatch = 0;
  int               n_checks   = 0;
  int               cyc        = 0;
  logic [7:0]       q;
  logic [8:0]       rx;
  mlis_slave dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .monitor_clock_line_i(scl), .monitor_clock_line_o(scl_o),
    .monitor_clock_line_oe_o(scl_oe), .monitor_data_line_i(sda),
    .monitor_data_line_o(sda_o), .monitor_data_line_oe_o(sda_oe),
    .irq_o(irq));
  mlis_host_model host_u (.scl_i(scl), .sda_i(sda), .scl_drv_o(scl_m),
    .sda_drv_o(sda_m));
  always #5 ref_clk_i = ~ref_clk_i;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // request held until the edge that samples waitrequest low
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk_i);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do @(posedge ref_clk_i); while (wt !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, e, "register");
  endtask : rchk
  // let the pin synchroniser and flag logic settle
  task automatic settle;
    repeat (10) @(posedge ref_clk_i);
  endtask : settle
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    settle();
    for (int k = 0; k < 6; k++) begin
      rchk(3'(k), 8'h00);
    end
    acc(1'b1, IDX_CONTROL, 8'h3D);
    rchk(IDX_CONTROL, 8'h20);
    acc(1'b1, IDX_CONTROL, 8'h3D);
    rchk(IDX_CONTROL, 8'h35);
    host_u.start_cond();
    host_u.xfer({8'h01, 1'b1}, rx);
    chk(8'(rx[0]), 8'h01, "start byte ack");
    host_u.stop_cond();
    acc(1'b1, IDX_OWN, 8'hA4);
    host_u.start_cond();
    host_u.xfer({8'h60, 1'b1}, rx);
    chk(8'(rx[0]), 8'h00, "alt ack");
    settle();
    chk(8'(scl_oe), 8'h01, "stretch");
    chk(8'(irq), 8'h01, "irq");
    rchk(IDX_ERROR, 8'h01);
    rchk(IDX_EVENT, 8'h94);
    acc(1'b0, IDX_DATA, 8'h00);
    chk(8'(q[0]), 8'h00, "role");
    host_u.xfer({8'h5A, 1'b1}, rx);
    chk(8'(rx[0]), 8'h00, "data ack");
    settle();
    rchk(IDX_EVENT, 8'h98);
    rchk(IDX_DATA, 8'h5A);
    rchk(IDX_EVENT, 8'h10);
    host_u.stop_cond();
    settle();
    rchk(IDX_EVENT, 8'h80);
    rchk(IDX_ERROR, 8'h08);
    rchk(IDX_ERROR, 8'h00);
    host_u.start_cond();
    host_u.xfer({8'hA5, 1'b1}, rx);
    chk(8'(rx[0]), 8'h00, "own ack");
    settle();
    rchk(IDX_EVENT, 8'h94);
    acc(1'b0, IDX_DATA, 8'h00);
    acc(1'b1, IDX_DATA, 8'hC3);
    host_u.xfer({8'hFF, 1'b0}, rx);
    chk(rx[8:1], 8'hC3, "tx byte");
    settle();
    chk(8'(scl_oe), 8'h01, "tx stretch");
    rchk(IDX_EVENT, 8'hB8);
    acc(1'b1, IDX_DATA, 8'h3C);
    host_u.xfer({8'hFF, 1'b1}, rx);
    chk(rx[8:1], 8'h3C, "next tx byte");
    settle();
    chk(8'(scl_oe), 8'h00, "no stretch");
    rchk(IDX_ERROR, 8'h10);
    host_u.stop_cond();
    host_u.start_cond();
    host_u.pulse(1'b1);
    host_u.stop_cond();
    settle();
    rchk(IDX_ERROR, 8'h0A);
    acc(1'b1, IDX_CONTROL, 8'h00);
    rchk(IDX_CONTROL, 8'h00);
    rchk(IDX_OWN, 8'hA4);
    stop_test();
  end
endmodule : mlis_slave_tb
